// ---- pkg/srxlc_consts.vh ----
// constants for the s/pdif receiver lock and control block
// assumes inclusion by bare name from design files under one include path
//
// Behaviour
// - The lock flag reads 0 while no valid stream is locked and 1 once locked.
// - With quick acquire cleared, lock is declared after 64 valid samples in a row.
// - With quick acquire set, lock is declared after eight valid samples in a row.
// - With unlock policy 0 the frame clock keeps running as best it can after lock is lost.
// - With unlock policy 1 the frame clock output stops at once when lock is lost.
// - The unlock policy acts on the recovered frame clock output.
// - Length codes 00, 01 and 10 select 24, 20 and 16 bit audio words.
// - Length code 11 takes the word length from the stream's channel status bits.
// - The control register reads all zeros after reset.
// - The lock status register reads zero after reset until lock is reached.
// - Audio output is muted automatically when lock is lost.
`ifndef SRXLC_CONSTS_VH
`define SRXLC_CONSTS_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define SRXLC_IDX_LOCK_STATUS 16'hF600
`define SRXLC_IDX_RX_CONTROL  16'hF601
`define SRXLC_IDX_IRQ_STATUS  16'hF610
`define SRXLC_IDX_IRQ_MASK    16'hF611
`define SRXLC_IDX_WORD_LEN    16'hF612
`define SRXLC_ADDR_W          18

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define SRXLC_BIT_LOCK        0
`define SRXLC_BIT_QUICK       3
`define SRXLC_BIT_POLICY      2
`define SRXLC_LEN_MSB         1
`define SRXLC_LEN_LSB         0
`define SRXLC_CTRL_W          4
`define SRXLC_CTRL_RESET      4'h0
`define SRXLC_LOCK_RESET      1'h0
`define SRXLC_BIT_EV_ACQ      0
`define SRXLC_BIT_EV_LOSS     1
`define SRXLC_IRQ_W           2
`define SRXLC_IRQ_RESET       2'h0

// ----------------------------------------------------------------
// lock counts and word length codes
// ----------------------------------------------------------------
`define SRXLC_RUN_NORMAL      7'h40
`define SRXLC_RUN_QUICK       7'h08
`define SRXLC_LEN_24          2'h0
`define SRXLC_LEN_20          2'h1
`define SRXLC_LEN_16          2'h2
`define SRXLC_LEN_AUTO        2'h3
`define SRXLC_CS_16           4'h2
`define SRXLC_CS_17           4'hC
`define SRXLC_CS_18           4'h4
`define SRXLC_CS_19           4'h8
`define SRXLC_CS_20           4'hA
`define SRXLC_CS_21           4'hD
`define SRXLC_CS_22           4'h5
`define SRXLC_CS_23           4'h9
`define SRXLC_CS_24           4'hB
`define SRXLC_CS_20B          4'h3

`endif

// ---- design/srxlc_lock_det.v ----
// consecutive-valid-sample lock detector
// assumes sample strobes come from decoder logic on the same core clock
`timescale 1ns/1ps
`default_nettype none
`include "srxlc_consts.vh"

module srxlc_lock_det #(
    parameter [6:0] RUN_NORMAL = `SRXLC_RUN_NORMAL,
    parameter [6:0] RUN_QUICK  = `SRXLC_RUN_QUICK
) (
    input  wire       clk,
    input  wire       srst,
    input  wire       sample_stb,
    input  wire       sample_ok,
    input  wire       quick_sel,
    output reg        locked_reg,
    output reg        acquire_pulse_reg,
    output reg        loss_pulse_reg
);

    // ------------------------------------------------------------
    // run counter and lock state
    // ------------------------------------------------------------
    reg  [6:0] run_reg;
    wire [6:0] target;

    assign target = quick_sel ? RUN_QUICK : RUN_NORMAL;

    // one invalid sample is enough to drop lock; no hysteresis
    always @(posedge clk) begin
        if (srst) begin
            run_reg           <= 7'h00;
            locked_reg        <= `SRXLC_LOCK_RESET;
            acquire_pulse_reg <= 1'b0;
            loss_pulse_reg    <= 1'b0;
        end else begin
            acquire_pulse_reg <= 1'b0;
            loss_pulse_reg    <= 1'b0;
            if (sample_stb) begin
                if (!sample_ok) begin
                    run_reg <= 7'h00;
                    if (locked_reg) begin
                        locked_reg     <= 1'b0;
                        loss_pulse_reg <= 1'b1;
                    end
                end else if (!locked_reg) begin
                    if (run_reg + 7'h01 >= target) begin
                        locked_reg        <= 1'b1;
                        acquire_pulse_reg <= 1'b1;
                        run_reg           <= 7'h00;
                    end else begin
                        run_reg <= run_reg + 7'h01;
                    end
                end
            end
        end
    end

endmodule // srxlc_lock_det

`default_nettype wire

// ---- design/srxlc_top.v ----
// s/pdif receiver lock control with avalon-mm register slave
// assumes decoder front end, frame clock and channel status on CORE_CLK
// assumes software waits for the lock flag before trusting the audio
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "srxlc_consts.vh"

module srxlc_top (
    input  wire                     CORE_CLK,
    input  wire                     SRST,
    input  wire [`SRXLC_ADDR_W-1:0] AVS_ADDRESS,
    input  wire                     AVS_READ,
    input  wire                     AVS_WRITE,
    input  wire [31:0]              AVS_WRITEDATA,
    input  wire [3:0]               AVS_BYTEENABLE,
    output wire [31:0]              AVS_READDATA,
    output wire                     AVS_WAITREQUEST,
    input  wire                     SAMPLE_STB,
    input  wire                     SAMPLE_OK,
    input  wire [23:0]              SAMPLE_DATA,
    input  wire                     FRAME_CLK_IN,
    input  wire [3:0]               CS_WORD_CODE,
    output wire                     AUDIO_STB,
    output wire [23:0]              AUDIO_DATA,
    output wire                     FRAME_CLK_OUT,
    output wire                     AUDIO_MUTE,
    output wire [4:0]               WORD_LEN,
    output wire                     IRQ
);

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    reg  [`SRXLC_CTRL_W-1:0] ctrl_reg;
    reg  [`SRXLC_IRQ_W-1:0]  irq_stat_reg;
    reg  [`SRXLC_IRQ_W-1:0]  irq_stat_next;
    reg  [`SRXLC_IRQ_W-1:0]  irq_mask_reg;
    reg  [31:0]              rdata_reg;
    reg                      ack_reg;
    reg  [31:0]              rdata_next;
    // word length state is read by the register mux, so it is
    // declared here rather than next to its logic
    reg  [4:0]               cs_len;
    reg  [4:0]               eff_len;

    // lock detector outputs and decoded control fields
    wire                     locked;
    wire                     acq_pulse;
    wire                     loss_pulse;
    wire                     quick_sel;
    wire                     unlock_output_policy;
    wire [1:0]               word_length_sel;

    // control fields; reserved bits are never stored
    assign quick_sel            = ctrl_reg[`SRXLC_BIT_QUICK];
    assign unlock_output_policy = ctrl_reg[`SRXLC_BIT_POLICY];
    assign word_length_sel      = ctrl_reg[`SRXLC_LEN_MSB:`SRXLC_LEN_LSB];

    // ------------------------------------------------------------
    // lock detector
    // ------------------------------------------------------------
    // counts come from the shared header so software and bench agree;
    // the detector keeps its own run counter, the bus cannot reset it
    srxlc_lock_det #(
        .RUN_NORMAL (`SRXLC_RUN_NORMAL),
        .RUN_QUICK  (`SRXLC_RUN_QUICK)
    ) u_lock (
        .clk               (CORE_CLK),
        .srst              (SRST),
        .sample_stb        (SAMPLE_STB),
        .sample_ok         (SAMPLE_OK),
        .quick_sel         (quick_sel),
        .locked_reg        (locked),
        .acquire_pulse_reg (acq_pulse),
        .loss_pulse_reg    (loss_pulse)
    );

    // ------------------------------------------------------------
    // avalon-mm slave: fixed one wait state per access
    // ------------------------------------------------------------
    // request decode; the index is the word address
    wire        req;
    wire        wr_take;
    wire [15:0] idx;
    wire        aligned;

    assign req     = AVS_READ | AVS_WRITE;
    // waitrequest drops in the second cycle of each request
    assign AVS_WAITREQUEST = req & ~ack_reg;
    assign wr_take = AVS_WRITE & ack_reg;
    assign idx     = AVS_ADDRESS[`SRXLC_ADDR_W-1:2];
    assign aligned = (AVS_ADDRESS[1:0] == 2'h0);
    assign AVS_READDATA = rdata_reg;

    // ack toggles so back-to-back requests each see one wait state
    always @(posedge CORE_CLK) begin
        if (SRST) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req & ~ack_reg;
        end
    end

    // read mux; unmapped or misaligned addresses read zero
    // reserved bits of every register read as zero as well
    always @* begin
        rdata_next = 32'h0000_0000;
        if (aligned) begin
            case (idx)
                `SRXLC_IDX_LOCK_STATUS: begin
                    rdata_next[`SRXLC_BIT_LOCK] = locked;
                end
                `SRXLC_IDX_RX_CONTROL: begin
                    rdata_next[`SRXLC_CTRL_W-1:0] = ctrl_reg;
                end
                `SRXLC_IDX_IRQ_STATUS: begin
                    rdata_next[`SRXLC_IRQ_W-1:0] = irq_stat_reg;
                end
                `SRXLC_IDX_IRQ_MASK: begin
                    rdata_next[`SRXLC_IRQ_W-1:0] = irq_mask_reg;
                end
                `SRXLC_IDX_WORD_LEN: begin
                    rdata_next[4:0] = eff_len;
                end
                default: begin
                    rdata_next = 32'h0000_0000;
                end
            endcase
        end
    end

    // read data captured in the waiting cycle, stands at the ack edge
    // so a read never sees a value change under the master
    always @(posedge CORE_CLK) begin
        if (SRST) begin
            rdata_reg <= 32'h0000_0000;
        end else if (AVS_READ & ~ack_reg) begin
            rdata_reg <= rdata_next;
        end
    end

    // ------------------------------------------------------------
    // control and mask writes, low byte lane only holds live bits
    // ------------------------------------------------------------
    // a write with the low lane off is dropped: every live bit is in it
    always @(posedge CORE_CLK) begin
        if (SRST) begin
            ctrl_reg     <= `SRXLC_CTRL_RESET;
            irq_mask_reg <= `SRXLC_IRQ_RESET;
        end else if (wr_take && aligned && AVS_BYTEENABLE[0]) begin
            if (idx == `SRXLC_IDX_RX_CONTROL) begin
                ctrl_reg <= AVS_WRITEDATA[`SRXLC_CTRL_W-1:0];
            end
            if (idx == `SRXLC_IDX_IRQ_MASK) begin
                irq_mask_reg <= AVS_WRITEDATA[`SRXLC_IRQ_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt status: write one to clear, new event wins
    // ------------------------------------------------------------
    // clear first, then events, so an event in the clearing cycle stays
    always @* begin
        irq_stat_next = irq_stat_reg;
        if (wr_take && aligned && AVS_BYTEENABLE[0] &&
            idx == `SRXLC_IDX_IRQ_STATUS) begin
            irq_stat_next = irq_stat_reg &
                            ~AVS_WRITEDATA[`SRXLC_IRQ_W-1:0];
        end
        if (acq_pulse) begin
            irq_stat_next[`SRXLC_BIT_EV_ACQ] = 1'b1;
        end
        if (loss_pulse) begin
            irq_stat_next[`SRXLC_BIT_EV_LOSS] = 1'b1;
        end
    end

    // sticky status; only a bus write of one takes a bit down
    always @(posedge CORE_CLK) begin
        if (SRST) begin
            irq_stat_reg <= `SRXLC_IRQ_RESET;
        end else begin
            irq_stat_reg <= irq_stat_next;
        end
    end

    // level interrupt: any unmasked sticky event
    assign IRQ = |(irq_stat_reg & irq_mask_reg);

    // ------------------------------------------------------------
    // word length selection
    // ------------------------------------------------------------
    // unknown channel status codes fall back to the widest word; a
    // code outside the table must not shorten the audio word
    always @* begin
        case (CS_WORD_CODE)
            `SRXLC_CS_16:  cs_len = 5'h10;
            `SRXLC_CS_17:  cs_len = 5'h11;
            `SRXLC_CS_18:  cs_len = 5'h12;
            `SRXLC_CS_19:  cs_len = 5'h13;
            `SRXLC_CS_20:  cs_len = 5'h14;
            `SRXLC_CS_20B: cs_len = 5'h14;
            `SRXLC_CS_21:  cs_len = 5'h15;
            `SRXLC_CS_22:  cs_len = 5'h16;
            `SRXLC_CS_23:  cs_len = 5'h17;
            `SRXLC_CS_24:  cs_len = 5'h18;
            default:       cs_len = 5'h18;
        endcase
    end

    // fixed codes win; only code 11 follows the channel status
    always @* begin
        case (word_length_sel)
            `SRXLC_LEN_24:   eff_len = 5'h18;
            `SRXLC_LEN_20:   eff_len = 5'h14;
            `SRXLC_LEN_16:   eff_len = 5'h10;
            `SRXLC_LEN_AUTO: eff_len = cs_len;
            default:         eff_len = 5'h18;
        endcase
    end

    // effective length is also shown on a pin for the data path
    assign WORD_LEN = eff_len;

    // ------------------------------------------------------------
    // audio path: truncate to word length, mute while unlocked
    // ------------------------------------------------------------
    reg  [23:0] len_mask;
    reg  [23:0] audio_reg;
    reg         audio_stb_reg;
    reg         mute_reg;
    integer     b;

    // clear every bit below the selected word length
    always @* begin
        len_mask = 24'h00_0000;
        for (b = 0; b < 24; b = b + 1) begin
            len_mask[b] = (b >= (24 - eff_len));
        end
    end

    // mute follows the lock flag; relock unmutes, restart policy
    // lives in a separate register block
    always @(posedge CORE_CLK) begin
        if (SRST) begin
            mute_reg      <= 1'b1;
            audio_reg     <= 24'h00_0000;
            audio_stb_reg <= 1'b0;
        end else begin
            mute_reg      <= ~locked | loss_pulse;
            audio_stb_reg <= SAMPLE_STB & locked;
            if (SAMPLE_STB) begin
                if (locked && SAMPLE_OK) begin
                    audio_reg <= SAMPLE_DATA & len_mask;
                end else begin
                    audio_reg <= 24'h00_0000;
                end
            end else if (!locked) begin
                audio_reg <= 24'h00_0000;
            end
        end
    end

    // all audio outputs come straight from flip-flops
    assign AUDIO_DATA = audio_reg;
    assign AUDIO_STB  = audio_stb_reg;
    assign AUDIO_MUTE = mute_reg;

    // ------------------------------------------------------------
    // recovered frame clock output under the unlock policy
    // ------------------------------------------------------------
    reg fclk_reg;
    reg fclk_seen_reg;

    // policy 0 keeps passing the clock once any lock was seen, at the
    // cost of possibly corrupt timing; policy 1 gates it while unlocked
    always @(posedge CORE_CLK) begin
        if (SRST) begin
            fclk_reg      <= 1'b0;
            fclk_seen_reg <= 1'b0;
        end else begin
            if (acq_pulse) begin
                fclk_seen_reg <= 1'b1;
            end
            if (locked) begin
                fclk_reg <= FRAME_CLK_IN;
            end else if (unlock_output_policy) begin
                fclk_reg <= 1'b0;
            end else if (fclk_seen_reg) begin
                fclk_reg <= FRAME_CLK_IN;
            end else begin
                fclk_reg <= 1'b0;
            end
        end
    end

    // one cycle behind the incoming frame clock while passed; held low under policy 1 while unlocked and before any lock
    assign FRAME_CLK_OUT = fclk_reg;

endmodule // srxlc_top

`default_nettype wire

// ---- bench/srxlc_tx_model.sv ----
// transmitter model: strobed samples with frame clock
// assumes the core clock; the bench calls send
`timescale 1ns/1ps
`default_nettype none
module srxlc_tx_model (
    input  wire logic        CORE_CLK,
    output logic             SAMPLE_STB,
    output logic             SAMPLE_OK,
    output logic [23:0]      SAMPLE_DATA,
    output logic             FRAME_CLK_IN
);
    logic [23:0] pat = 24'h5A3C96;
    logic [23:0] last = 24'h0;
    initial begin
        SAMPLE_STB = 1'b0;
        SAMPLE_OK = 1'b0;
        SAMPLE_DATA = 24'h0;
        FRAME_CLK_IN = 1'b0;
    end
    // --------
    // one sample per two cycles
    // --------
    // idle data is inverted so no stale word looks valid
    task automatic send(input int n, input logic good);
        for (int i = 0; i < n; i++) begin
            @(posedge CORE_CLK);
            SAMPLE_STB <= 1'b1;
            SAMPLE_OK <= good;
            SAMPLE_DATA <= pat;
            last <= pat;
            FRAME_CLK_IN <= ~FRAME_CLK_IN;
            @(posedge CORE_CLK);
            SAMPLE_STB <= 1'b0;
            SAMPLE_DATA <= ~pat;
            pat <= {pat[22:0], pat[23] ^ pat[18]};
        end
        #1;
    endtask
endmodule // srxlc_tx_model
`default_nettype wire

// ---- bench/srxlc_checker.sv ----
// checker on the lock control top ports
// assumes bind into srxlc_top; control bits mirrored from bus writes
`timescale 1ns/1ps
`default_nettype none
`include "srxlc_consts.vh"
module srxlc_checker (
    input wire logic        CORE_CLK,
    input wire logic        SRST,
    input wire logic [17:0] AVS_ADDRESS,
    input wire logic        AVS_READ,
    input wire logic        AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0]  AVS_BYTEENABLE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic        AVS_WAITREQUEST,
    input wire logic        SAMPLE_STB,
    input wire logic        SAMPLE_OK,
    input wire logic        FRAME_CLK_IN,
    input wire logic        AUDIO_STB,
    input wire logic [23:0] AUDIO_DATA,
    input wire logic        FRAME_CLK_OUT,
    input wire logic        AUDIO_MUTE,
    input wire logic [4:0]  WORD_LEN
);
    logic       pol_reg;
    logic [1:0] len_reg;
    logic       seen_reg;
    logic       wr_ctl;
    assign wr_ctl = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0]
        && AVS_ADDRESS == {`SRXLC_IDX_RX_CONTROL, 2'b00};
    // mirror of control; seen marks a lock since reset
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            pol_reg <= 1'b0;
            len_reg <= 2'h0;
            seen_reg <= 1'b0;
        end else begin
            if (wr_ctl) begin
                pol_reg <= AVS_WRITEDATA[2];
                len_reg <= AVS_WRITEDATA[1:0];
            end
            if (!AUDIO_MUTE)
                seen_reg <= 1'b1;
        end
    end
    // --------
    // properties
    // --------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SRST);
    bus_wait_a: assert property ($rose(AVS_READ || AVS_WRITE)
        |-> AVS_WAITREQUEST) else $error("first cycle not held");
    bus_answer_a: assert property ((AVS_READ || AVS_WRITE)
        && AVS_WAITREQUEST |=> !AVS_WAITREQUEST) else $error("no answer");
    read_upper_a: assert property (AVS_READ && !AVS_WAITREQUEST
        |-> AVS_READDATA[31:16] == 16'h0) else $error("upper bits set");
    strobe_cause_a: assert property (AUDIO_STB
        |-> $past(SAMPLE_STB)) else $error("audio without sample");
    muted_quiet_a: assert property (AUDIO_MUTE && $past(AUDIO_MUTE)
        |-> !AUDIO_STB) else $error("audio while muted");
    loss_mute_a: assert property (SAMPLE_STB && !SAMPLE_OK
        && !AUDIO_MUTE |-> ##2 AUDIO_MUTE) else $error("no mute on loss");
    policy_stop_a: assert property (pol_reg && $past(pol_reg)
        && AUDIO_MUTE |-> !FRAME_CLK_OUT) else $error("frame clock runs");
    policy_keep_a: assert property (!pol_reg && !$past(pol_reg)
        && seen_reg && $past(seen_reg)
        |-> FRAME_CLK_OUT == $past(FRAME_CLK_IN)) else $error("clock lost");
    fixed_len_a: assert property (len_reg != 2'h3 |-> WORD_LEN ==
        (len_reg == 2'h0 ? 5'h18 : len_reg == 2'h1 ? 5'h14 : 5'h10))
        else $error("word length wrong");
    data_mask_a: assert property (AUDIO_STB |-> (AUDIO_DATA &
        ~(24'hFFFFFF << (5'h18 - WORD_LEN))) == 24'h0)
        else $error("low bits not masked");
    cover property ($fell(AUDIO_MUTE));
    cover property ($rose(AUDIO_MUTE));
    cover property (pol_reg && AUDIO_MUTE && FRAME_CLK_IN);
endmodule // srxlc_checker
`default_nettype wire

// ---- bench/srxlc_top_tb.sv ----
// self-checking bench for the receiver lock control block
// assumes the design header on the include path; one core clock
`timescale 1ns/1ps
`default_nettype none
`include "srxlc_consts.vh"
module srxlc_top_tb;
    logic        CORE_CLK = 1'b0;
    logic        SRST = 1'b1;
    logic [17:0] AVS_ADDRESS = 18'h0;
    logic        AVS_READ = 1'b0;
    logic        AVS_WRITE = 1'b0;
    logic [31:0] AVS_WRITEDATA = 32'h0;
    logic [3:0]  AVS_BYTEENABLE = 4'h0;
    logic [3:0]  CS_WORD_CODE = 4'h0;
    wire  [31:0] AVS_READDATA;
    wire  [23:0] SAMPLE_DATA, AUDIO_DATA;
    wire  [4:0]  WORD_LEN;
    wire         AVS_WAITREQUEST, SAMPLE_STB, SAMPLE_OK, FRAME_CLK_IN;
    wire         AUDIO_STB, FRAME_CLK_OUT, AUDIO_MUTE, IRQ;
    int          errors = 0;
    int          checks_done = 0;
    // unknown code 0 last, taken as 24 bits
    logic [3:0]  cs_tab [11] = '{`SRXLC_CS_16, `SRXLC_CS_17, `SRXLC_CS_18,
        `SRXLC_CS_19, `SRXLC_CS_20, `SRXLC_CS_21, `SRXLC_CS_22,
        `SRXLC_CS_23, `SRXLC_CS_24, `SRXLC_CS_20B, 4'h0};
    logic [4:0]  cs_len [11] = '{5'h10, 5'h11, 5'h12, 5'h13, 5'h14,
        5'h15, 5'h16, 5'h17, 5'h18, 5'h14, 5'h18};
    logic [4:0]  fix_len [3] = '{5'h18, 5'h14, 5'h10};
    always #12.5 CORE_CLK = ~CORE_CLK;
    srxlc_tx_model tx (.*);
    srxlc_top uut (.*);
    // --------
    // helpers
    // --------
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // request held until waitrequest is seen low at a rising edge;
    // read data taken and request released at that same edge
    task automatic bus(input logic w, input logic [15:0] idx,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge CORE_CLK);
        AVS_ADDRESS <= {idx, 2'b00};
        AVS_READ <= ~w;
        AVS_WRITE <= w;
        AVS_WRITEDATA <= d;
        AVS_BYTEENABLE <= 4'hF;
        @(posedge CORE_CLK);
        while (AVS_WAITREQUEST !== 1'b0) begin
            n++;
            if (n > 20) begin
                errors++;
                summarize();
            end
            @(posedge CORE_CLK);
        end
        q = AVS_READDATA;
        AVS_READ <= 1'b0;
        AVS_WRITE <= 1'b0;
        #1;
    endtask
    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, q);
    endtask
    task automatic rdc(input string what, input logic [15:0] idx,
                       input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, idx, 32'h0, q);
        chk(what, q, exp);
    endtask
    task automatic do_reset();
        @(posedge CORE_CLK);
        SRST <= 1'b1;
        repeat (6) @(posedge CORE_CLK);
        SRST <= 1'b0;
    endtask
    // --------
    // scenarios
    // --------
    task automatic t_reset();
        rdc("lock", `SRXLC_IDX_LOCK_STATUS, 32'h0);
        rdc("ctrl", `SRXLC_IDX_RX_CONTROL, 32'h0);
        rdc("unmapped", 16'hF620, 32'h0);
        chk("mute", {31'h0, AUDIO_MUTE}, 32'h1);
        chk("len", {27'h0, WORD_LEN}, 32'h18);
        $display("test reset done");
    endtask
    task automatic t_normal();
        wr(`SRXLC_IDX_IRQ_MASK, 32'h3);
        tx.send(63, 1'b1);
        rdc("lock 63", `SRXLC_IDX_LOCK_STATUS, 32'h0);
        chk("irq idle", {31'h0, IRQ}, 32'h0);
        tx.send(1, 1'b1);
        rdc("lock 64", `SRXLC_IDX_LOCK_STATUS, 32'h1);
        chk("unmute", {31'h0, AUDIO_MUTE}, 32'h0);
        chk("irq lock", {31'h0, IRQ}, 32'h1);
        rdc("acq ev", `SRXLC_IDX_IRQ_STATUS, 32'h1);
        wr(`SRXLC_IDX_IRQ_STATUS, 32'h1);
        chk("irq clr", {31'h0, IRQ}, 32'h0);
        tx.send(1, 1'b1);
        chk("astb", {31'h0, AUDIO_STB}, 32'h1);
        chk("adata", {8'h0, AUDIO_DATA}, {8'h0, tx.last});
        $display("test normal lock done");
    endtask
    task automatic t_loss();
        tx.send(1, 1'b0);
        rdc("lock lost", `SRXLC_IDX_LOCK_STATUS, 32'h0);
        chk("mute", {31'h0, AUDIO_MUTE}, 32'h1);
        rdc("loss ev", `SRXLC_IDX_IRQ_STATUS, 32'h2);
        wr(`SRXLC_IDX_IRQ_MASK, 32'h1);
        chk("irq masked", {31'h0, IRQ}, 32'h0);
        wr(`SRXLC_IDX_IRQ_MASK, 32'h3);
        chk("irq open", {31'h0, IRQ}, 32'h1);
        wr(`SRXLC_IDX_IRQ_STATUS, 32'h2);
        chk("irq clr", {31'h0, IRQ}, 32'h0);
        tx.send(1, 1'b0);
        chk("fclk kept", 32'(FRAME_CLK_OUT), 32'(FRAME_CLK_IN));
        $display("test loss done");
    endtask
    task automatic t_quick();
        wr(`SRXLC_IDX_RX_CONTROL, 32'h8);
        tx.send(7, 1'b1);
        tx.send(1, 1'b0);
        tx.send(7, 1'b1);
        rdc("run reset", `SRXLC_IDX_LOCK_STATUS, 32'h0);
        tx.send(1, 1'b1);
        rdc("lock 8", `SRXLC_IDX_LOCK_STATUS, 32'h1);
        $display("test quick lock done");
    endtask
    task automatic t_len();
        logic [23:0] m;
        for (int c = 0; c < 3; c++) begin
            wr(`SRXLC_IDX_RX_CONTROL, 32'hFFF8 | 32'(c));
            rdc("ctrl rb", `SRXLC_IDX_RX_CONTROL, 32'h8 | 32'(c));
            chk("len", {27'h0, WORD_LEN}, {27'h0, fix_len[c]});
            tx.send(1, 1'b1);
            m = 24'hFFFFFF << (5'h18 - fix_len[c]);
            chk("mdata", {8'h0, AUDIO_DATA}, {8'h0, tx.last & m});
        end
        wr(`SRXLC_IDX_RX_CONTROL, 32'hB);
        for (int i = 0; i < 11; i++) begin
            @(posedge CORE_CLK);
            CS_WORD_CODE <= cs_tab[i];
            @(posedge CORE_CLK);
            #1;
            chk("auto len", {27'h0, WORD_LEN}, {27'h0, cs_len[i]});
        end
        rdc("len reg", `SRXLC_IDX_WORD_LEN, 32'h18);
        $display("test word length done");
    endtask
    task automatic t_policy();
        wr(`SRXLC_IDX_RX_CONTROL, 32'hC);
        tx.send(1, 1'b0);
        for (int i = 0; i < 2; i++) begin
            tx.send(1, 1'b0);
            chk("fclk stop", {31'h0, FRAME_CLK_OUT}, 32'h0);
        end
        // ten samples leave the incoming frame clock high
        tx.send(10, 1'b1);
        chk("fclk run", 32'(FRAME_CLK_OUT), 32'(FRAME_CLK_IN));
        chk("relock audio", {31'h0, AUDIO_STB}, 32'h1);
        $display("test policy done");
    endtask
    initial begin
        do_reset();
        t_reset();
        t_normal();
        t_loss();
        t_quick();
        t_len();
        t_policy();
        do_reset();
        t_reset();
        summarize();
    end
endmodule // srxlc_top_tb
bind srxlc_top srxlc_checker chk_i (.*);
`default_nettype wire
